// ---- led_pwm_defines.svh ----
// Register offsets, reset values and timing counts of the LED intensity PWM block.
// Assumes the includer needs plain text macros only.
`ifndef LED_PWM_DEFINES_SVH
`define LED_PWM_DEFINES_SVH
// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define PORT_PHASE_OFS 8'h00
`define NINTH_PHASE_OFS 8'h04
`define CONFIG_OFS 8'h08
`define MASTER_OFS 8'h0C
`define INTENS_LO_OFS 8'h10
`define INTENS_HI_OFS 8'h14
`define STATUS_OFS 8'h18
// -----------------------------------------------------------------------------
// Reset values and field positions
// -----------------------------------------------------------------------------
`define PORT_PHASE_RST 8'hFF
`define NINTH_PHASE_RST 1'h1
`define CONFIG_RST 1'h0
`define MASTER_RST 8'h00
`define INTENS_RST 16'hFFFF
`define GLOBAL_BIT 0
`define STATIC_CODE 4'hF
`define MASTER_LAST 4'hE
`define STAT_OSC_BIT 8
`define STAT_PIN_LSB 16
// -----------------------------------------------------------------------------
// Timing: clock cycles per PWM slot; bus response codes
// -----------------------------------------------------------------------------
`define SLOT_CYCLES 8'h04
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- led_pwm_pkg.sv ----
// Types shared by the LED intensity PWM files.
// Assumes nothing of its surroundings.
package led_pwm_pkg;
    // A 4-bit intensity code.
    typedef logic [3:0] intensity_t;
    // Write channel progress of the register slave.
    typedef enum logic {WR_COLLECT, WR_ANSWER} wr_state_t;
endpackage : led_pwm_pkg

// ---- pwm_slot_timer.sv ----
// Slot and master timeslot counters shared by every output.
// Assumes one clock; the master code comes from a register on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "led_pwm_defines.svh"
module pwm_slot_timer
(
    input wire logic clock,
    input wire logic rst_b,
    input wire led_pwm_pkg::intensity_t master,
    output logic [3:0] slot_q,
    output logic [3:0] master_cnt_q,
    output logic osc_on_q
);
    import led_pwm_pkg::*;
    logic [7:0] div_q, div_d; // Cycle divider inside one slot.
    logic [3:0] slot_d, master_cnt_d;
    logic osc_on_d;
    logic tick; // One-cycle slot enable.

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    // A zero master code stops the oscillator and parks all counters at zero.
    always_comb
    begin
        osc_on_d = (master != 4'h0);
        tick = (div_q == `SLOT_CYCLES - 8'h01);
        div_d = tick ? 8'h00 : div_q + 8'h01;
        slot_d = slot_q;
        master_cnt_d = master_cnt_q;
        if (!osc_on_q)
        begin
            div_d = 8'h00;
            slot_d = 4'h0;
            master_cnt_d = 4'h0;
        end
        else if (tick)
        begin
            slot_d = slot_q + 4'h1;
            if (slot_q == 4'hF)
            begin
                // Fifteen master timeslots make the 240-step frame.
                master_cnt_d = (master_cnt_q == `MASTER_LAST) ? 4'h0 : master_cnt_q + 4'h1;
            end
        end
    end

    // Registers only.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_q <= 8'h00;
            slot_q <= 4'h0;
            master_cnt_q <= 4'h0;
            osc_on_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            slot_q <= slot_d;
            master_cnt_q <= master_cnt_d;
            osc_on_q <= osc_on_d;
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    a_slot_step: assert property (@(posedge clock) disable iff (!rst_b)
        (osc_on_q && tick) |=> (slot_q == $past(slot_q) + 4'h1))
        else $error("Slot counter did not advance on its tick.");
    a_master_wrap: assert property (@(posedge clock) disable iff (!rst_b)
        master_cnt_q <= `MASTER_LAST)
        else $error("Master timeslot counter passed fifteen slots.");
endmodule : pwm_slot_timer
`default_nettype wire

// ---- pwm_output_cell.sv ----
// One open-drain output: turns intensity, phase bit and slot into a low drive.
// Assumes slot and master timing come from the shared slot timer.
`timescale 1ns/10ps
`default_nettype none
`include "led_pwm_defines.svh"
module pwm_output_cell
(
    input wire logic clock,
    input wire logic rst_b,
    input wire led_pwm_pkg::intensity_t intensity,
    input wire logic phase_bit,
    input wire logic [3:0] slot,
    input wire logic master_on,
    input wire logic osc_on,
    output logic drive_low_q
);
    import led_pwm_pkg::*;
    logic drive_low_d;
    logic active; // Inside the first n+1 slots.

    // -------------------------------------------------------------------------
    // Drive decision
    // -------------------------------------------------------------------------
    // A phase bit of 0 sinks during the active slots, a 1 floats during them.
    always_comb
    begin
        active = (slot <= intensity);
        if (intensity == `STATIC_CODE || !osc_on)
        begin
            drive_low_d = !phase_bit;
        end
        else
        begin
            drive_low_d = master_on && (phase_bit ? !active : active);
        end
    end

    // Registered so the pin never glitches between slots.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            drive_low_q <= 1'b0;
        end
        else
        begin
            drive_low_q <= drive_low_d;
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    a_static_level: assert property (@(posedge clock) disable iff (!rst_b)
        (intensity == `STATIC_CODE) |=> (drive_low_q == !$past(phase_bit)))
        else $error("Static code did not give a static level.");
    a_pwm_low_part: assert property (@(posedge clock) disable iff (!rst_b)
        (osc_on && master_on && intensity != `STATIC_CODE && !phase_bit)
        |=> (drive_low_q == ($past(slot) <= $past(intensity))))
        else $error("Low part of the period has the wrong length.");
    a_pwm_float_part: assert property (@(posedge clock) disable iff (!rst_b)
        (osc_on && master_on && intensity != `STATIC_CODE && phase_bit)
        |=> (drive_low_q == ($past(slot) > $past(intensity))))
        else $error("Floating part of the period has the wrong length.");
endmodule : pwm_output_cell
`default_nettype wire

// ---- led_intensity_pwm.sv ----
// Top of the LED intensity PWM block: AXI4-Lite registers, slot timer, nine outputs.
// Assumes one 40 MHz clock; the pins are open drain with external pullups.
//
// Notes on behaviour
// - Codes 0x0-0xE: active for (n+1)/16 period.
// - Code 0xF: static level from phase bit.
// - Eight ports share one phase register.
// - Ninth output has its own phase register.
// - Global flag: ninth intensity drives all outputs.
// - Master and intensity give 240 steps.
// - Master zero stops oscillator; outputs static.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "led_pwm_defines.svh"
module led_intensity_pwm
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [7:0] port_output_in,
    output logic [7:0] port_output_out,
    output logic [7:0] port_output_oe,
    input wire logic ninth_output_in,
    output logic ninth_output_out,
    output logic ninth_output_oe
);
    import led_pwm_pkg::*;

    // -------------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------------
    logic [7:0] port_phase_q, port_phase_d; // Common phase bits of the eight ports.
    logic ninth_phase_q, ninth_phase_d; // Phase bit of the ninth output alone.
    logic global_q, global_d; // Global intensity flag.
    logic [7:0] master_q, master_d; // Master code high, ninth intensity low.
    logic [31:0] intens_q, intens_d; // Four bits per port, port 0 lowest.
    logic [3:0] slot; // Current PWM slot.
    logic [3:0] master_cnt; // Current master timeslot.
    logic osc_on; // Oscillator running.
    logic master_on; // This master timeslot carries PWM.
    intensity_t eff [0:8]; // Intensity each output actually uses.
    logic [8:0] phase_vec; // Phase bit of each output.
    logic [8:0] drive_low; // Low drive of each output.
    logic [8:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q, pin_d; // Pin level sampling.

    // -------------------------------------------------------------------------
    // Bus channel state
    // -------------------------------------------------------------------------
    wr_state_t wr_state_q, wr_state_d; // Collecting or answering a write.
    logic aw_held_q, aw_held_d; // Write address taken.
    logic w_held_q, w_held_d; // Write data taken.
    logic [7:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d;
    logic [31:0] rd_word; // Read lookup.
    logic rd_hit; // Read address is mapped.
    logic wr_hit; // Write address is mapped.
    logic [31:0] wmask; // Byte mask from the strobes.

    // -------------------------------------------------------------------------
    // Shared slot timer and nine output cells
    // -------------------------------------------------------------------------
    pwm_slot_timer u_timer
    (
        .clock(clock),
        .rst_b(rst_b),
        .master(master_q[7:4]),
        .slot_q(slot),
        .master_cnt_q(master_cnt),
        .osc_on_q(osc_on)
    );

    // Master timeslots below the master code carry PWM, the rest stay dark.
    assign master_on = (master_cnt < master_q[7:4]);

    // Ports 0-7 read one register, the ninth output its own one.
    assign phase_vec = {ninth_phase_q, port_phase_q};

    // With the global flag all outputs take the ninth output's intensity.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            eff[i] = global_q ? master_q[3:0] : intens_q[4*i +: 4];
        end
        eff[8] = master_q[3:0];
    end

    // All cells share one slot counter, so ports with equal phase and intensity switch together.
    for (genvar g = 0; g < 9; g++)
    begin : g_cell
        pwm_output_cell u_cell
        (
            .clock(clock),
            .rst_b(rst_b),
            .intensity(eff[g]),
            .phase_bit(phase_vec[g]),
            .slot(slot),
            .master_on(master_on),
            .osc_on(osc_on),
            .drive_low_q(drive_low[g])
        );
    end

    // Open drain: the pin is driven, always low, only when the cell sinks.
    assign port_output_oe = drive_low[7:0];
    assign ninth_output_oe = drive_low[8];

    // -------------------------------------------------------------------------
    // Pin level sampling
    // -------------------------------------------------------------------------
    // A level counts once the second and third stages agree.
    always_comb
    begin
        pin_d = pin_q;
        for (int i = 0; i < 9; i++)
        begin
            if (pin_s2_q[i] == pin_s3_q[i])
            begin
                pin_d[i] = pin_s3_q[i];
            end
        end
    end

    // -------------------------------------------------------------------------
    // Write channel
    // -------------------------------------------------------------------------
    // Address and data are taken in either order; the answer follows both.
    always_comb
    begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        wr_state_d = wr_state_q;
        bvalid_d = bvalid;
        bresp_d = bresp;
        port_phase_d = port_phase_q;
        ninth_phase_d = ninth_phase_q;
        global_d = global_q;
        master_d = master_q;
        intens_d = intens_q;
        wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
        wr_hit = 1'b1;
        unique case (wr_state_q)
            WR_COLLECT:
            begin
                if (awvalid && awready)
                begin
                    aw_held_d = 1'b1;
                    waddr_d = awaddr;
                end
                if (wvalid && wready)
                begin
                    w_held_d = 1'b1;
                    wdata_d = wdata;
                    wstrb_d = wstrb;
                end
                if (aw_held_q && w_held_q)
                begin
                    // Writes land one cycle after the second half is taken.
                    unique case (waddr_q)
                        `PORT_PHASE_OFS: port_phase_d = wstrb_q[0] ? wdata_q[7:0] : port_phase_q;
                        `NINTH_PHASE_OFS: ninth_phase_d = wstrb_q[0] ? wdata_q[0] : ninth_phase_q;
                        `CONFIG_OFS: global_d = wstrb_q[0] ? wdata_q[`GLOBAL_BIT] : global_q;
                        `MASTER_OFS: master_d = wstrb_q[0] ? wdata_q[7:0] : master_q;
                        `INTENS_LO_OFS: intens_d[15:0] = (intens_q[15:0] & ~wmask[15:0])
                            | (wdata_q[15:0] & wmask[15:0]);
                        `INTENS_HI_OFS: intens_d[31:16] = (intens_q[31:16] & ~wmask[15:0])
                            | (wdata_q[15:0] & wmask[15:0]);
                        default: wr_hit = 1'b0;
                    endcase
                    aw_held_d = 1'b0;
                    w_held_d = 1'b0;
                    bvalid_d = 1'b1;
                    bresp_d = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                    wr_state_d = WR_ANSWER;
                end
            end
            WR_ANSWER:
            begin
                if (bready)
                begin
                    bvalid_d = 1'b0;
                    wr_state_d = WR_COLLECT;
                end
            end
        endcase
        awready_d = (wr_state_d == WR_COLLECT) && !aw_held_d;
        wready_d = (wr_state_d == WR_COLLECT) && !w_held_d;
    end

    // -------------------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------------------
    // One read at a time; the data stand from the same edge that takes the address.
    always_comb
    begin
        rd_hit = 1'b1;
        unique case (araddr)
            `PORT_PHASE_OFS: rd_word = {24'h000000, port_phase_q};
            `NINTH_PHASE_OFS: rd_word = {31'h00000000, ninth_phase_q};
            `CONFIG_OFS: rd_word = {31'h00000000, global_q};
            `MASTER_OFS: rd_word = {24'h000000, master_q};
            `INTENS_LO_OFS: rd_word = {16'h0000, intens_q[15:0]};
            `INTENS_HI_OFS: rd_word = {16'h0000, intens_q[31:16]};
            `STATUS_OFS: rd_word = {7'h00, pin_q, 7'h00, osc_on, master_cnt, slot};
            default:
            begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
        rvalid_d = rvalid;
        rdata_d = rdata;
        rresp_d = rresp;
        if (arvalid && arready)
        begin
            rvalid_d = 1'b1;
            rdata_d = rd_word;
            rresp_d = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid_d = 1'b0;
        end
        arready_d = !rvalid_d;
    end

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    // Reset leaves every output floating and the oscillator stopped.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port_phase_q <= `PORT_PHASE_RST;
            ninth_phase_q <= `NINTH_PHASE_RST;
            global_q <= `CONFIG_RST;
            master_q <= `MASTER_RST;
            intens_q <= {2{`INTENS_RST}};
            wr_state_q <= WR_COLLECT;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
            pin_s1_q <= 9'h000;
            pin_s2_q <= 9'h000;
            pin_s3_q <= 9'h000;
            pin_q <= 9'h000;
            port_output_out <= 8'h00;
            ninth_output_out <= 1'b0;
        end
        else
        begin
            port_phase_q <= port_phase_d;
            ninth_phase_q <= ninth_phase_d;
            global_q <= global_d;
            master_q <= master_d;
            intens_q <= intens_d;
            wr_state_q <= wr_state_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready <= awready_d;
            wready <= wready_d;
            bvalid <= bvalid_d;
            bresp <= bresp_d;
            arready <= arready_d;
            rvalid <= rvalid_d;
            rdata <= rdata_d;
            rresp <= rresp_d;
            pin_s1_q <= {ninth_output_in, port_output_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q <= pin_d;
            // Open drain only ever sinks, so the driven value stays low.
            port_output_out <= 8'h00;
            ninth_output_out <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    a_ports_together: assert property (@(posedge clock) disable iff (!rst_b)
        (port_phase_q[0] == port_phase_q[1] && eff[0] == eff[1]
        && $stable(port_phase_q[1:0]) && $stable({eff[0], eff[1]}))
        |=> (port_output_oe[0] == port_output_oe[1]))
        else $error("Ports with equal settings switched apart.");
    a_ninth_own_phase: assert property (@(posedge clock) disable iff (!rst_b)
        (master_q[3:0] == `STATIC_CODE && $stable(ninth_phase_q))
        |=> (ninth_output_oe == !$past(ninth_phase_q)))
        else $error("Ninth output ignored its own phase bit.");
    a_global_select: assert property (@(posedge clock) disable iff (!rst_b)
        global_q |-> (eff[3] == master_q[3:0] && eff[7] == master_q[3:0]))
        else $error("Global flag did not select the ninth intensity.");
    a_master_stop: assert property (@(posedge clock) disable iff (!rst_b)
        (master_q[7:4] == 4'h0) |=> !osc_on ##1 (slot == 4'h0))
        else $error("Oscillator kept running with master code zero.");
    a_master_dark: assert property (@(posedge clock) disable iff (!rst_b)
        (osc_on && !master_on && !port_phase_q[2] && eff[2] != `STATIC_CODE)
        |=> !port_output_oe[2])
        else $error("Output sank outside the master timeslots.");
    a_write_answer: assert property (@(posedge clock) disable iff (!rst_b)
        (aw_held_q && w_held_q && !bvalid) |=> bvalid)
        else $error("Write answer did not follow both halves.");
    c_pwm_running: cover property (@(posedge clock) disable iff (!rst_b)
        osc_on && master_on && port_output_oe[0] ##1 !port_output_oe[0]);
    c_global_on: cover property (@(posedge clock) disable iff (!rst_b)
        global_q && osc_on);
    c_read_done: cover property (@(posedge clock) disable iff (!rst_b)
        rvalid && rready);
endmodule : led_intensity_pwm
`default_nettype wire

// ---- led_load_model.sv ----
// Open-drain loads with pullups on the nine outputs.
// Assumes the block only sinks; a released pin is pulled high.
`timescale 1ns/10ps
`default_nettype none
module led_load_model
(
    input wire logic [8:0] sink_oe,
    output logic [8:0] pin_level
);
    // -------------------------------------------------------------------------
    // Pin levels
    // -------------------------------------------------------------------------
    // A released pin goes to the pullup level, never to the last driven value.
    assign pin_level = ~sink_oe;
endmodule : led_load_model
`default_nettype wire

// ---- led_output_intensity_pwm_tb.sv ----
// Self-checking bench: AXI4-Lite register access and duty counts on the pins.
// Assumes the defines header and the 4-cycle slot length of the design.
`timescale 1ns/10ps
`default_nettype none
`include "led_pwm_defines.svh"
module led_output_intensity_pwm_tb;
    logic clock, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, ninth_oe, ninth_out;
    logic [7:0] port_oe, port_out;
    logic [8:0] pins;
    int fails, checks_done, diff;
    int cnt [9];
    wire logic [8:0] oe9 = {ninth_oe, port_oe};
    led_intensity_pwm i_dut (.clock(clock), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .port_output_in(pins[7:0]), .port_output_out(port_out), .port_output_oe(port_oe),
        .ninth_output_in(pins[8]), .ninth_output_out(ninth_out), .ninth_output_oe(ninth_oe));
    led_load_model i_load (.sink_oe(oe9), .pin_level(pins));
    // -------------------------------------------------------------------------
    // Bus and check tasks
    // -------------------------------------------------------------------------
    // Address and data are offered together; bready stays high until bvalid.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        fork
            begin do @(posedge clock); while (!awready); awvalid <= 1'b0; end
            begin do @(posedge clock); while (!wready); wvalid <= 1'b0; end
        join
        do @(posedge clock); while (!bvalid);
        bready <= 1'b0; r = bresp;
    endtask : wr
    // Read data is taken at the same edge that sees rvalid high.
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        rready <= 1'b0; d = rdata; r = rresp;
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One whole frame of 15 periods is counted, so the start phase does not matter.
    task automatic meas();
        repeat (64) @(posedge clock);
        cnt = '{default:0}; diff = 0;
        for (int i = 0; i < 960; i++)
        begin
            @(posedge clock);
            for (int k = 0; k < 9; k++) cnt[k] += oe9[k];
            if (oe9[0] !== oe9[4]) diff++;
        end
    endtask : meas
    function automatic logic [31:0] ex(input int n, input int m);
        return 32'(n * `SLOT_CYCLES * m);
    endfunction : ex
    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic t_reset();
        rd(`MASTER_OFS); chk(d, 0);
        rd(`INTENS_LO_OFS); chk(d, 32'h0000FFFF);
        rd(8'h1C); chk({r, d[29:0]}, 32'h80000000);
        wr(8'h1C, 32'h0); chk(32'(r), 32'h2);
        chk(32'(oe9), 0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_static();
        wr(`PORT_PHASE_OFS, 0); chk(32'(r), `RESP_OKAY);
        wr(`INTENS_LO_OFS, 32'h3333); wr(`MASTER_OFS, 32'h0F); meas();
        chk(32'(cnt[0]), 960);
        chk(32'(cnt[7]), 960);
        chk(32'(cnt[8]), 0);
        rd(`STATUS_OFS); chk(d, 32'h01000000);
        $display("t_static done");
    endtask : t_static
    task automatic t_duty();
        int n [3] = '{0, 7, 14};
        wr(`MASTER_OFS, 32'hF0); wr(`PORT_PHASE_OFS, 32'h02);
        foreach (n[j])
        begin
            wr(`INTENS_LO_OFS, 32'hFF00 | 32'(n[j] * 17)); meas();
            chk(32'(cnt[0]), ex(n[j] + 1, 15));
            chk(32'(cnt[1]), ex(15 - n[j], 15));
        end
        $display("t_duty done");
    endtask : t_duty
    task automatic t_master();
        wr(`PORT_PHASE_OFS, 0); wr(`MASTER_OFS, 32'h50);
        wr(`INTENS_LO_OFS, 32'hF303); wr(`INTENS_HI_OFS, 32'hFFF3); meas();
        chk(32'(cnt[0]), ex(4, 5));
        chk(32'(cnt[2]), ex(4, 5));
        chk(32'(cnt[3]), 960);
        chk(32'(diff), 0);
        $display("t_master done");
    endtask : t_master
    task automatic t_ninth();
        wr(`CONFIG_OFS, 1); wr(`MASTER_OFS, 32'hF6); wr(`NINTH_PHASE_OFS, 0); meas();
        chk(32'(cnt[0]), ex(7, 15));
        chk(32'(cnt[8]), ex(7, 15));
        wr(`NINTH_PHASE_OFS, 1); meas();
        chk(32'(cnt[8]), ex(9, 15));
        chk(32'(cnt[5]), ex(7, 15));
        rd(`MASTER_OFS); chk(d, 32'hF6);
        wr(`MASTER_OFS, 32'h06); meas();
        chk(32'(cnt[0]), 960);
        chk(32'(cnt[8]), 0);
        chk(32'({port_out, ninth_out}), 0);
        $display("t_ninth done");
    endtask : t_ninth
    task automatic wrap_up();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // -------------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // -------------------------------------------------------------------------
    initial
    begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    initial
    begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF;
        fails = 0; checks_done = 0;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        t_reset(); t_static(); t_duty(); t_master(); t_ninth();
        wrap_up();
    end
    // About 8,300 cycles are expected; the limit leaves ample margin.
    initial
    begin
        repeat (40000) @(posedge clock);
        fails++;
        wrap_up();
    end
endmodule : led_output_intensity_pwm_tb
`default_nettype wire
